// File: sbt_params.svh
// Register map, field positions, reset values and counts for the timer
// ----------------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------------
// Functional notes
// - Sixteen-bit up-counter reached as high byte and low byte registers.
// - A write to either count byte loads the live count at once.
// - Timer on, instruction clock, 1:1 prescale: one count per instruction cycle.
// - Control bit 1 picks system clock (1) or instruction clock (0).
// - With system clock selected the count grows four per instruction cycle.
// - Control bits 5-4 divide the clock by 1, 2, 4 or 8.
// - The prescale counter can be neither read nor written by software.
// - Any write to a count byte clears the prescale counter.
// - Control bit 0 gates counting; zero stops timer and clears gate flop.
// - Count wraps FFFFh to 0000h and sets the rollover flag.
// - Interrupt needs on bit, rollover, peripheral and global enables set.
// - Counting stops in sleep; the timer never wakes the device.
// - Control bits 7-6 and 3-2 read zero and ignore writes.
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SBT_ADDR_W 3
`define SBT_OFF_COUNT_LOW 3'h0
`define SBT_OFF_COUNT_HIGH 3'h1
`define SBT_OFF_CONTROL 3'h2
`define SBT_OFF_FLAG 3'h3
`define SBT_OFF_ENABLE 3'h4
`define SBT_OFF_INT_CONTROL 3'h5
`define SBT_OFF_FLAG_CLEAR 3'h6

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define SBT_CTL_ON_BIT 0
`define SBT_CTL_CS_BIT 1
`define SBT_CTL_PS_LSB 4
`define SBT_CTL_PS_MSB 5
`define SBT_CTL_MASK 8'h33
`define SBT_INT_MASK 8'hc0
`define SBT_FLAG_ROLL_BIT 0
`define SBT_INT_PERIPHERAL_INTERRUPT_ENABLE_BIT 6
`define SBT_INT_GIE_BIT 7

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SBT_CTL_RESET 8'h00
`define SBT_INT_RESET 8'h00
`define SBT_COUNT_RESET 16'h0000
`define SBT_INSTR_DIV 4

`endif

// File: sbt_pkg.sv
// Types shared by the timer modules
package sbt_pkg;
    typedef logic [7:0] sbt_byte_t;
    typedef logic [15:0] sbt_count_t;
endpackage : sbt_pkg

// File: sbt_tick_gen.sv
// Source selection and prescaler producing the count tick
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module sbt_tick_gen
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic sys_clk_sel,
    input wire logic [1:0] prescale_sel,
    input wire logic prescale_clear,
    // Tick out
    output logic tick
);
    logic [1:0] phase_q;
    logic [2:0] pre_q;
    logic src_tick;
    logic pre_done;

    // ------------------------------------------------------------------
    // Instruction cycle phase: one in four system clocks
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
            phase_q <= 2'h0;
        else if (ce)
            phase_q <= phase_q + 2'h1;
    end

    assign src_tick = sys_clk_sel ? 1'b1 : (phase_q == 2'h3);

    // ------------------------------------------------------------------
    // Hidden prescale counter
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (prescale_sel)
            2'h0: pre_done = 1'b1;
            2'h1: pre_done = (pre_q[0] == 1'b1);
            2'h2: pre_done = (pre_q[1:0] == 2'h3);
            2'h3: pre_done = (pre_q == 3'h7);
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            pre_q <= 3'h0;
        else if (ce)
        begin
            if (prescale_clear || !run)
                pre_q <= 3'h0;
            else if (src_tick)
                pre_q <= pre_done ? 3'h0 : pre_q + 3'h1;
        end
    end

    assign tick = ce && run && src_tick && pre_done;
endmodule : sbt_tick_gen
`default_nettype wire

// File: sbt_irq.sv
// Rollover flag, enables and interrupt output
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module sbt_irq
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Event and software control
    input wire logic roll_event,
    input wire logic flag_clear,
    input wire logic enable_wr,
    input wire logic enable_val,
    input wire logic periph_en,
    input wire logic global_en,
    input wire logic timer_on,
    // State
    output logic flag,
    output logic enable,
    output logic irq
);
    logic flag_q;
    logic enable_q;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            flag_q <= 1'b0;
        else if (ce)
        begin
            if (roll_event)
                flag_q <= 1'b1;
            else if (flag_clear)
                flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            enable_q <= 1'b0;
        else if (ce && enable_wr)
            enable_q <= enable_val;
    end

    assign flag = flag_q;
    assign enable = enable_q;
    assign irq = flag_q && enable_q && periph_en && global_en &&
                 timer_on;
endmodule : sbt_irq
`default_nettype wire

// File: sbt_timer.sv
// Sixteen-bit interval timer with register port
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module sbt_timer
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Processor state
    input wire logic sleep,
    // Register port
    input wire logic [`SBT_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Interrupt
    output logic irq
);
    sbt_count_t count_q;
    sbt_byte_t ctl_q;
    sbt_byte_t int_ctl_q;
    sbt_byte_t rdata_q;
    logic tick;
    logic count_wr;
    logic roll;
    logic flag;
    logic enable;
    logic gate_q;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
            ctl_q <= `SBT_CTL_RESET;
        else if (ce && wr && addr == `SBT_OFF_CONTROL)
            ctl_q <= wdata & `SBT_CTL_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            int_ctl_q <= `SBT_INT_RESET;
        else if (ce && wr && addr == `SBT_OFF_INT_CONTROL)
            int_ctl_q <= wdata & `SBT_INT_MASK;
    end

    // Gate flip-flop follows the on bit and clears when off
    always_ff @(posedge clk)
    begin
        if (!rstn)
            gate_q <= 1'b0;
        else if (ce)
            gate_q <= ctl_q[`SBT_CTL_ON_BIT];
    end

    assign count_wr = wr && (addr == `SBT_OFF_COUNT_LOW ||
                             addr == `SBT_OFF_COUNT_HIGH);

    sbt_tick_gen u_tick (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .run(gate_q && ctl_q[`SBT_CTL_ON_BIT] && !sleep),
        .sys_clk_sel(ctl_q[`SBT_CTL_CS_BIT]),
        .prescale_sel(ctl_q[`SBT_CTL_PS_MSB:`SBT_CTL_PS_LSB]),
        .prescale_clear(count_wr),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign roll = tick && !count_wr && (count_q == 16'hffff);

    always_ff @(posedge clk)
    begin
        if (!rstn)
            count_q <= `SBT_COUNT_RESET;
        else if (ce)
        begin
            if (wr && addr == `SBT_OFF_COUNT_LOW)
                count_q[7:0] <= wdata;
            else if (wr && addr == `SBT_OFF_COUNT_HIGH)
                count_q[15:8] <= wdata;
            else if (tick)
                count_q <= count_q + 16'h0001;
        end
    end

    sbt_irq u_irq (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .roll_event(roll),
        .flag_clear(wr && addr == `SBT_OFF_FLAG_CLEAR &&
                    wdata[`SBT_FLAG_ROLL_BIT]),
        .enable_wr(wr && addr == `SBT_OFF_ENABLE),
        .enable_val(wdata[`SBT_FLAG_ROLL_BIT]),
        .periph_en(int_ctl_q[`SBT_INT_PERIPHERAL_INTERRUPT_ENABLE_BIT]),
        .global_en(int_ctl_q[`SBT_INT_GIE_BIT]),
        .timer_on(ctl_q[`SBT_CTL_ON_BIT]),
        .flag(flag),
        .enable(enable),
        .irq(irq)
    );

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
            rdata_q <= 8'h00;
        else if (ce)
        begin
            if (rd)
            begin
                unique case (addr)
                    `SBT_OFF_COUNT_LOW: rdata_q <= count_q[7:0];
                    `SBT_OFF_COUNT_HIGH: rdata_q <= count_q[15:8];
                    `SBT_OFF_CONTROL: rdata_q <= ctl_q;
                    `SBT_OFF_FLAG: rdata_q <= {7'h00, flag};
                    `SBT_OFF_ENABLE: rdata_q <= {7'h00, enable};
                    `SBT_OFF_INT_CONTROL: rdata_q <= int_ctl_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
            else
                rdata_q <= 8'h00;
        end
    end

    assign rdata = rdata_q;
endmodule : sbt_timer
`default_nettype wire

// File: sbt_timer_checker.sv
// Assertions on the timer register port and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module sbt_timer_checker
    import sbt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sleep,
    // Register port
    input wire logic [`SBT_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Interrupt
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic w = wr && ce;
    wire logic r = rd && ce;
    a_ctl_reserved: assert property (r && addr == 3'h2 |=>
        (rdata & 8'hcc) == 8'h00) else $error("control reserved bits set");
    a_ctl_store: assert property (w && addr == 3'h2 ##1
        r && addr == 3'h2 |=> rdata == ($past(wdata, 2) & 8'h33))
        else $error("control readback");
    a_low_load: assert property (w && addr == 3'h0 ##1 r && addr == 3'h0
        |=> rdata == $past(wdata, 2)) else $error("low byte load");
    a_high_load: assert property (w && addr == 3'h1 ##1
        r && addr == 3'h1 |=> rdata == $past(wdata, 2))
        else $error("high byte load");
    a_int_gate: assert property (w && addr == 3'h5 &&
        wdata[7:6] != 2'b11 |=> !irq) else $error("irq without global enables");
    a_on_gate: assert property (w && addr == 3'h2 && !wdata[0] |=> !irq)
        else $error("irq with timer off");
    a_en_gate: assert property (w && addr == 3'h4 && !wdata[0] |=> !irq)
        else $error("irq with enable clear");
    a_flag_sticky: assert property (irq && !w |=> irq)
        else $error("irq dropped with no write");
    c_irq: cover property ($rose(irq));
    c_flag: cover property (r && addr == 3'h3 ##1 rdata[0]);
    c_load: cover property (w && addr == 3'h0 ##1 r);
endmodule : sbt_timer_checker
bind sbt_timer sbt_timer_checker chk_u (.clk(clk), .rstn(rstn), .ce(ce),
    .sleep(sleep), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
`default_nettype wire

// File: sbt_timer_tb_top.sv
// Self-checking bench for the interval timer
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module sbt_timer_tb_top
    import sbt_pkg::*;
;
    logic clk = 0, rstn = 0, sleep = 0, wr = 0, rd = 0, ce = 1;
    logic [2:0] addr = 3'h0;
    sbt_byte_t wdata = 8'h00, rdata, v, c, ok;
    logic irq;
    int err_count = 0, num_checks = 0, n;
    logic [2:0] ga[4] = '{3'h5, 3'h5, 3'h4, 3'h2};
    sbt_byte_t gv[4] = '{8'h80, 8'h40, 8'h00, 8'h02};
    sbt_byte_t gr[4] = '{8'hc0, 8'hc0, 8'h01, 8'h03};
    initial forever #12.5 clk = ~clk;
    sbt_timer dut_u (.clk(clk), .rstn(rstn), .ce(ce), .sleep(sleep),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq));
    task chk(input string s, input sbt_byte_t e, input sbt_byte_t g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task wr_reg(input logic [2:0] a, input sbt_byte_t d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task rd_reg(input logic [2:0] a, output sbt_byte_t d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask : rd_reg
    task wr_rd(input logic [2:0] a, input sbt_byte_t d, output sbt_byte_t q);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd_reg(a, q);
    endtask : wr_rd
    task t_regs;
        wr_rd(3'h1, 8'h12, v);
        chk("count high", 8'h12, v);
        wr_rd(3'h0, 8'h34, v);
        chk("count low", 8'h34, v);
        wr_rd(3'h5, 8'hff, v);
        chk("int control", 8'hc0, v);
        wr_rd(3'h4, 8'hff, v);
        chk("enable", 8'h01, v);
        $display("test regs done");
    endtask : t_regs
    task t_rates;
        for (int m = 0; m < 8; m++)
        begin
            n = 202 / (((m & 1) ? 1 : 4) << (m >> 1));
            c = 8'h01 | 8'(m & 1) << 1 | 8'(m >> 1) << 4;
            wr_reg(3'h1, 8'h00);
            wr_reg(3'h0, 8'h00);
            wr_rd(3'h2, c | 8'hcc, v);
            chk("control", c, v);
            repeat (200) @(posedge clk);
            wr_reg(3'h2, 8'h00);
            repeat (2) begin
                rd_reg(3'h0, v);
                ok = 8'(v >= n - 2 && v <= n + 2);
                chk("rate", 8'h01, ok);
                repeat (40) @(posedge clk);
            end
        end
        $display("test rates done");
    endtask : t_rates
    task t_sleep;
        sleep <= 1'b1;
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h2, 8'h03);
        repeat (50) @(posedge clk);
        wr_reg(3'h2, 8'h00);
        sleep <= 1'b0;
        rd_reg(3'h0, v);
        chk("sleep count", 8'h00, v);
        $display("test sleep done");
    endtask : t_sleep
    task t_ce;
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h2, 8'h03);
        ce <= 1'b0;
        repeat (50) @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        wr_reg(3'h2, 8'h00);
        rd_reg(3'h0, v);
        chk("frozen count", 8'h02, v);
        wr_reg(3'h2, 8'h03);
        wr_reg(3'h2, 8'h00);
        rd_reg(3'h0, v);
        chk("resumed count", 8'h03, v);
        $display("test ce done");
    endtask : t_ce
    task t_roll;
        wr_reg(3'h6, 8'h01);
        wr_reg(3'h1, 8'hff);
        wr_reg(3'h0, 8'hf0);
        wr_reg(3'h4, 8'h01);
        wr_reg(3'h5, 8'hc0);
        wr_reg(3'h2, 8'h03);
        for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk);
        chk("irq rise", 8'h01, 8'(irq));
        if (irq !== 1'b1)
            return;
        rd_reg(3'h3, v);
        chk("flag", 8'h01, v);
        rd_reg(3'h1, v);
        chk("wrapped high", 8'h00, v);
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(ga[k], gv[k]);
            chk("irq gated", 8'h00, 8'(irq));
            wr_reg(ga[k], gr[k]);
            chk("irq back", 8'h01, 8'(irq));
        end
        wr_reg(3'h4, 8'h00);
        wr_reg(3'h6, 8'h01);
        wr_reg(3'h1, 8'hff);
        wr_reg(3'h0, 8'hf0);
        repeat (40) @(posedge clk);
        rd_reg(3'h3, v);
        chk("polled flag", 8'h01, v);
        chk("irq masked", 8'h00, 8'(irq));
        wr_reg(3'h6, 8'h01);
        rd_reg(3'h3, v);
        chk("flag cleared", 8'h00, v);
        $display("test roll done");
    endtask : t_roll
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_rates();
        t_sleep();
        t_ce();
        t_roll();
        summarize();
    end
endmodule : sbt_timer_tb_top
`default_nettype wire
